// *** shared/rsw_params.svh ***
// Constants for the reset supervisor and watchdog
// Behaviour
// [R01] Manual reset input held low keeps the reset output asserted.
// [R02] After manual reset release, reset stays asserted one full timeout.
// [R03] Reset timeout equals 4.94e6 times reset timing capacitance.
// [R04] Basic watchdog period equals 4.94e6 times watchdog timing capacitance.
// [R05] Basic variant: grounded watchdog timing pin disables the watchdog.
// [R06] Range select low uses basic period, high uses 128 times it.
// [R07] Any change of range select clears the watchdog timer.
// [R08] Windowed slow limit equals 0.65e9 times watchdog timing capacitance.
// [R09] Windowed fast limit is slow limit divided by strap-selected ratio.
// [R10] Windowed: strap0 high with strap1 low disables the watchdog.
// [R11] Strap0 helps select a window ratio or the disabled state.
// [R12] Basic: missing falling kick within the period gives a reset pulse.
// [R13] Windowed: kick sooner than fast or later than slow gives reset.
// [R14] Timer clears on valid kick and in reset, counts after release.
// [R15] Straps map to ratios 8, 16, 64 or disabled via a parameter.
// [R16] All capacitor-set durations are clock counts loaded from parameters.
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH

// Clock and capacitor timing constants
`define RSW_CLK_PERIOD_NS   5
`define RSW_RST_NS_PER_PF   4940
`define RSW_WDOG_NS_PER_PF  4940
`define RSW_SLOW_NS_PER_PF  650000
`define RSW_EXT_MULT        32'h00000080
`define RSW_DEF_CAP_PF      100

// Strap map, 3-bit log2 ratio per {strap1,strap0}; zero disables
`define RSW_RATIO_MAP       12'hd03

// Register offsets
`define RSW_OFS_STATUS      8'h00
`define RSW_OFS_INT_EN      8'h04
`define RSW_OFS_INT_CLR     8'h08
`define RSW_OFS_STATE       8'h0c
`define RSW_OFS_COUNT       8'h10

// Status bit positions and reset values
`define RSW_EV_MANUAL       0
`define RSW_EV_LATE         1
`define RSW_EV_EARLY        2
`define RSW_EV_W            3
`define RSW_RST_EV          3'h0

`endif

// *** shared/rsw_pkg.sv ***
// Types for the reset supervisor and watchdog
package rsw_pkg;

    // Supervisor sequencer states
    typedef enum logic [2:0] {
        RSW_ST_HOLD  = 3'b001,
        RSW_ST_PULSE = 3'b010,
        RSW_ST_RUN   = 3'b100
    } rsw_fsm_t;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rsw_bus_req_t;

    // Complete block state
    typedef struct packed {
        rsw_fsm_t    fsm;
        logic [31:0] rst_cnt;
        logic [31:0] wd_cnt;
        logic        kick_prev;
        logic        range_prev;
        logic        rst_out_n;
        logic [2:0]  stat;
        logic [2:0]  int_en;
        logic [31:0] rd_data;
    } rsw_state_t;

endpackage

// *** testbench/rsw_host_model.sv ***
// Host processor model that kicks the watchdog at a set interval
`timescale 1ns/10ps
`default_nettype none

module rsw_host_model (
    // Clock and supervisor reset seen by the host
    input  wire logic        sys_clk,
    input  wire logic        reset_out_n,
    // Kick control from the bench
    input  wire logic        enable,
    input  wire logic [15:0] interval,
    // Kick line to the supervisor
    output logic             kick
);
    logic [15:0] cnt;

    initial begin
        kick = 1'b1;
        cnt  = 16'h0000;
    end

    // Falling kick every interval+1 cycles, quiet while held in reset
    always @(posedge sys_clk) begin
        if (!enable || reset_out_n !== 1'b1) begin
            cnt  <= 16'h0000;
            kick <= 1'b1;
        end else if (cnt >= interval) begin
            cnt  <= 16'h0000;
            kick <= 1'b0;
        end else begin
            cnt  <= cnt + 16'h0001;
            kick <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** testbench/rsw_top_tb.sv ***
// Self-checking bench for the reset supervisor, basic variant
`timescale 1ns/10ps
`default_nettype none

module rsw_top_tb;
    import rsw_pkg::*;
    localparam int RST = 20;
    localparam int BASE = 16;
    logic sys_clk, rst_n, mr_n, kick, range, irq, host_en, rout_n;
    logic [15:0] ival;
    logic [31:0] rdat, d, seed;
    rsw_bus_req_t req;
    int errors, checks, n;

    rsw_top #(.RST_CYC(RST), .BASE_CYC(BASE), .SLOW_CYC(640)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .manual_reset_n(mr_n),
        .wdog_kick_in(kick), .wdog_range_sel(range),
        .window_strap0(1'b0), .window_strap1(1'b0),
        .reset_out_n(rout_n), .bus_req(req), .rd_data(rdat), .irq(irq));

    rsw_host_model host (.sys_clk(sys_clk), .reset_out_n(rout_n),
        .enable(host_en), .interval(ival), .kick(kick));

    // Clock generation
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge sys_clk);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        req <= '0;
        #1 v = rdat;
    endtask

    // Count cycles with reset asserted over a span
    task automatic lows(input int span, output int c);
        c = 0;
        repeat (span) begin
            @(posedge sys_clk);
            #1 if (rout_n !== 1'b1) c++;
        end
    endtask

    // Cycles until reset output reaches a level, bounded
    task automatic until_lvl(input logic lvl, output int c);
        c = 0;
        do begin
            @(posedge sys_clk);
            #1 c++;
        end while (rout_n !== lvl && c < 3000);
    endtask

    task automatic wrap_up;
        $display("counts: checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        wrap_up;
    end

    initial begin
        errors = 0; checks = 0; seed = 32'h6893fbe1;
        rst_n = 1'b0; mr_n = 1'b1; range = 1'b0; req = '0;
        host_en = 1'b0; ival = 16'd8;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        until_lvl(1'b1, n);
        chk("powerup_release", 32'h1, {31'h0, rout_n});
        rd(8'h0c, d);
        chk("state_run", 32'h22, d);
        // Manual reset hold and timed release
        @(posedge sys_clk);
        mr_n <= 1'b0;
        lows(6, n);
        chk("manual_hold", 32'd6, n);
        @(posedge sys_clk);
        mr_n <= 1'b1;
        until_lvl(1'b1, n);
        chk("manual_release", RST + 1, n);
        rd(8'h00, d);
        chk("status_manual", 32'h1, d & 32'h7);
        wr(8'h08, 32'h7);
        rd(8'h00, d);
        chk("status_clr", 32'h0, d & 32'h7);
        $display("test manual done");
        // Random kick intervals inside the period
        host_en <= 1'b1;
        repeat (8) begin
            seed = lfsr(seed);
            ival <= 16'd2 + 16'(seed[2:0]);
            lows(60, n);
            chk("kick_ok", 32'h0, n);
        end
        $display("test kicks done");
        // Missed kick gives a timed pulse
        host_en <= 1'b0;
        until_lvl(1'b0, n);
        chk("late_fault", 32'h1, {31'h0, n <= BASE + 12});
        n = 0;
        while (rout_n === 1'b0 && n < 3000) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        chk("pulse_len", RST, n);
        rd(8'h00, d);
        chk("status_late", 32'h2, d & 32'h7);
        $display("test fault done");
        // Interrupt enable, read-only write, clear, unmapped read
        wr(8'h04, 32'h2);
        rd(8'h04, d);
        chk("int_en", 32'h2, d & 32'h7);
        chk("irq_set", 32'h1, {31'h0, irq});
        wr(8'h00, 32'h0);
        chk("irq_ro", 32'h1, {31'h0, irq});
        wr(8'h08, 32'h2);
        #1 chk("irq_clr", 32'h0, {31'h0, irq});
        rd(8'h20, d);
        chk("unmapped", 32'h0, d);
        $display("test irq done");
        // Extended range and clear on range change
        @(posedge sys_clk);
        range <= 1'b1;
        ival <= 16'd100;
        host_en <= 1'b1;
        lows(400, n);
        chk("ext_kicks", 32'h0, n);
        host_en <= 1'b0;
        lows(1500, n);
        chk("ext_wait", 32'h0, n);
        range <= 1'b0;
        @(posedge sys_clk);
        range <= 1'b1;
        lows(1500, n);
        chk("range_clear", 32'h0, n);
        until_lvl(1'b0, n);
        chk("ext_fault", 32'h1, {31'h0, n > 500 && n < 600});
        $display("test range done");
        wrap_up;
    end
endmodule
`default_nettype wire

// *** verilog/rsw_top.sv ***
// Reset supervisor with basic or windowed watchdog
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "rsw_params.svh"

module rsw_top #(
    parameter int          WINDOWED    = 0,
    parameter int          RST_CAP_PF  = `RSW_DEF_CAP_PF,
    parameter int          WDOG_CAP_PF = `RSW_DEF_CAP_PF,
    parameter int          RST_CYC     =
        `RSW_RST_NS_PER_PF * RST_CAP_PF / `RSW_CLK_PERIOD_NS,
    parameter int          BASE_CYC    =
        `RSW_WDOG_NS_PER_PF * WDOG_CAP_PF / `RSW_CLK_PERIOD_NS,
    parameter int          SLOW_CYC    =
        `RSW_SLOW_NS_PER_PF * WDOG_CAP_PF / `RSW_CLK_PERIOD_NS,
    parameter logic [11:0] RATIO_MAP   = `RSW_RATIO_MAP
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    // Supervisor pins
    input  wire logic            manual_reset_n,
    input  wire logic            wdog_kick_in,
    input  wire logic            wdog_range_sel,
    input  wire logic            window_strap0,
    input  wire logic            window_strap1,
    output logic                 reset_out_n,
    // Register port
    input  wire rsw_pkg::rsw_bus_req_t bus_req,
    output logic [31:0]          rd_data,
    // Interrupt
    output logic                 irq
);
    import rsw_pkg::*;

    // Durations as clock counts, never below one cycle
    localparam logic [31:0] RST_LAST  =
        (RST_CYC > 1) ? 32'(RST_CYC - 1) : 32'h00000000;
    localparam logic [31:0] BASE_LIM  =
        (BASE_CYC > 1) ? 32'(BASE_CYC) : 32'h00000001;
    localparam logic [31:0] EXT_LIM   = 32'(BASE_LIM * `RSW_EXT_MULT);
    localparam logic [31:0] SLOW_LIM  =
        (SLOW_CYC > 1) ? 32'(SLOW_CYC) : 32'h00000001;
    localparam logic        PIN_GND   = (WDOG_CAP_PF == 0);
    localparam logic        IS_WINDOW = (WINDOWED != 0);

    rsw_state_t  st_reg;
    rsw_state_t  st_next;
    logic [2:0]  ev;
    logic [2:0]  ratio_shift;
    logic        wd_en;
    logic [31:0] wd_lim;
    logic [31:0] fast_lim;
    logic        kick_fall;
    logic        range_chg;
    logic        early;
    logic        late;
    logic        kick_ok;
    logic        wr_clr;

    // Strap pair to log2 window ratio, zero meaning disabled
    function automatic logic [2:0] strap_ratio(input logic s1,
                                               input logic s0);
        logic [3:0] idx;
        idx = {2'b00, s1, s0} * 4'h3;
        strap_ratio = RATIO_MAP[idx +: 3]; // R11 R15
    endfunction

    // Watchdog enable and limits for the active variant
    always_comb begin
        ratio_shift = strap_ratio(window_strap1, window_strap0);
        if (IS_WINDOW) begin
            wd_en    = (ratio_shift != 3'h0); // R10
            wd_lim   = SLOW_LIM; // R08 R16
            fast_lim = SLOW_LIM >> ratio_shift; // R09
        end else begin
            wd_en    = !PIN_GND; // R05
            wd_lim   = wdog_range_sel ? EXT_LIM : BASE_LIM; // R04 R06
            fast_lim = 32'h00000000;
        end
    end

    // Kick edge, range change and fault decode
    always_comb begin
        kick_fall = st_reg.kick_prev & ~wdog_kick_in;
        range_chg = !IS_WINDOW && (st_reg.range_prev ^ wdog_range_sel);
        early     = IS_WINDOW && kick_fall && (st_reg.wd_cnt < fast_lim);
        kick_ok   = kick_fall && !early;
        late      = !kick_ok && !range_chg &&
                    (st_reg.wd_cnt >= wd_lim - 32'h00000001);
    end

    // Next-state logic
    always_comb begin
        st_next            = st_reg;
        ev                 = `RSW_RST_EV;
        st_next.kick_prev  = wdog_kick_in;
        st_next.range_prev = wdog_range_sel;
        st_next.rd_data    = 32'h00000000;
        wr_clr             = 1'b0;

        // Supervisor sequencer
        case (st_reg.fsm)
            RSW_ST_HOLD: begin
                st_next.rst_cnt = 32'h00000000;
                if (manual_reset_n) begin
                    st_next.fsm = RSW_ST_PULSE; // R02
                end
            end
            RSW_ST_PULSE: begin
                if (!manual_reset_n) begin
                    st_next.fsm     = RSW_ST_HOLD; // R01
                    st_next.rst_cnt = 32'h00000000;
                    ev[`RSW_EV_MANUAL] = 1'b1;
                end else if (st_reg.rst_cnt >= RST_LAST) begin
                    st_next.fsm     = RSW_ST_RUN; // R02 R03
                    st_next.rst_cnt = 32'h00000000;
                end else begin
                    st_next.rst_cnt = st_reg.rst_cnt + 32'h00000001; // R16
                end
            end
            RSW_ST_RUN: begin
                st_next.rst_cnt = 32'h00000000;
                if (!manual_reset_n) begin
                    st_next.fsm = RSW_ST_HOLD; // R01
                    ev[`RSW_EV_MANUAL] = 1'b1;
                end else if (wd_en && early) begin
                    st_next.fsm = RSW_ST_PULSE; // R13
                    ev[`RSW_EV_EARLY] = 1'b1;
                end else if (wd_en && late) begin
                    st_next.fsm = RSW_ST_PULSE; // R12 R13
                    ev[`RSW_EV_LATE] = 1'b1;
                end
            end
            default: begin
                st_next.fsm     = RSW_ST_PULSE;
                st_next.rst_cnt = 32'h00000000;
            end
        endcase

        // Watchdog timer, cleared in reset and on kicks
        if (st_reg.fsm != RSW_ST_RUN || st_next.fsm != RSW_ST_RUN ||
            !wd_en) begin
            st_next.wd_cnt = 32'h00000000; // R14
        end else if (kick_ok || range_chg) begin
            st_next.wd_cnt = 32'h00000000; // R07 R14
        end else begin
            st_next.wd_cnt = st_reg.wd_cnt + 32'h00000001;
        end

        // Reset output released only while running
        st_next.rst_out_n = (st_next.fsm == RSW_ST_RUN);

        // Register writes
        if (bus_req.wr) begin
            if (bus_req.addr == `RSW_OFS_INT_EN) begin
                st_next.int_en = bus_req.wdata[`RSW_EV_W-1:0];
            end else if (bus_req.addr == `RSW_OFS_INT_CLR) begin
                wr_clr = 1'b1;
            end
        end

        // Sticky status, a new event beats a clear
        if (wr_clr) begin
            st_next.stat = (st_reg.stat & ~bus_req.wdata[`RSW_EV_W-1:0]) | ev;
        end else begin
            st_next.stat = st_reg.stat | ev;
        end

        // Register reads, data valid one cycle later
        if (bus_req.rd) begin
            if (bus_req.addr == `RSW_OFS_STATUS) begin
                st_next.rd_data = {29'h0, st_reg.stat};
            end else if (bus_req.addr == `RSW_OFS_INT_EN) begin
                st_next.rd_data = {29'h0, st_reg.int_en};
            end else if (bus_req.addr == `RSW_OFS_STATE) begin
                st_next.rd_data = {26'h0, st_reg.fsm, IS_WINDOW,
                                   wd_en, !st_reg.rst_out_n};
            end else if (bus_req.addr == `RSW_OFS_COUNT) begin
                st_next.rd_data = st_reg.wd_cnt;
            end else begin
                st_next.rd_data = 32'h00000000;
            end
        end
    end

    // State register, power-up starts a reset pulse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.fsm        <= RSW_ST_PULSE;
            st_reg.rst_cnt    <= 32'h00000000;
            st_reg.wd_cnt     <= 32'h00000000;
            st_reg.kick_prev  <= 1'b0;
            st_reg.range_prev <= 1'b0;
            st_reg.rst_out_n  <= 1'b0;
            st_reg.stat       <= `RSW_RST_EV;
            st_reg.int_en     <= `RSW_RST_EV;
            st_reg.rd_data    <= 32'h00000000;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign reset_out_n = st_reg.rst_out_n;
    assign rd_data     = st_reg.rd_data;
    assign irq         = |(st_reg.stat & st_reg.int_en);

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    chk_manual_holds: assert property ( // R01
        !manual_reset_n |=> !reset_out_n
    ) else $error("reset output released during manual reset");

    chk_release_delay: assert property ( // R02
        $rose(reset_out_n) |->
            $past(st_reg.fsm) == RSW_ST_PULSE &&
            $past(st_reg.rst_cnt) == RST_LAST && $past(manual_reset_n)
    ) else $error("reset released without full timeout");

    chk_pulse_length: assert property ( // R03
        (st_reg.fsm == RSW_ST_PULSE && manual_reset_n &&
         st_reg.rst_cnt < RST_LAST) |=> !reset_out_n
    ) else $error("reset pulse shorter than timeout");

    chk_late_fault: assert property ( // R12
        (st_reg.fsm == RSW_ST_RUN && manual_reset_n && wd_en &&
         !kick_fall && !range_chg &&
         st_reg.wd_cnt == wd_lim - 32'h00000001)
            |=> st_reg.fsm == RSW_ST_PULSE && st_reg.stat[`RSW_EV_LATE]
    ) else $error("missed kick did not start reset pulse");

    chk_early_fault: assert property ( // R13
        (st_reg.fsm == RSW_ST_RUN && manual_reset_n && wd_en &&
         IS_WINDOW && kick_fall && st_reg.wd_cnt < fast_lim)
            |=> !reset_out_n && st_reg.stat[`RSW_EV_EARLY]
    ) else $error("early kick did not start reset pulse");

    chk_range_clear: assert property ( // R07
        (st_reg.fsm == RSW_ST_RUN && !IS_WINDOW &&
         $changed(wdog_range_sel)) |-> st_next.wd_cnt == 32'h00000000
    ) else $error("range change did not clear timer");

    chk_ext_range: assert property ( // R06
        (st_reg.fsm == RSW_ST_RUN && !IS_WINDOW && !range_chg) |->
            st_reg.wd_cnt < (wdog_range_sel ? EXT_LIM : BASE_LIM)
    ) else $error("watchdog timer beyond selected period");

    chk_disabled: assert property ( // R10
        !wd_en |=> st_reg.wd_cnt == 32'h00000000 && $stable(st_reg.stat[2:1])
    ) else $error("disabled watchdog still active");

    chk_reset_clears: assert property ( // R14
        !reset_out_n |-> st_reg.wd_cnt == 32'h00000000
    ) else $error("watchdog timer counting during reset");

    chk_fast_limit: assert property ( // R09
        IS_WINDOW && wd_en |-> fast_lim == (SLOW_LIM >> ratio_shift)
    ) else $error("fast limit not derived from slow limit");

    chk_set_wins: assert property ( // R13
        (ev != 3'h0) |=> ((st_reg.stat & $past(ev)) == $past(ev))
    ) else $error("status event lost against clear");

    // Sequencer checks
    chk_hold_state: assert property ( // R01
        !manual_reset_n |=> st_reg.fsm == RSW_ST_HOLD
    ) else $error("manual reset did not enter hold");

    chk_hold_count: assert property ( // R02
        st_reg.fsm == RSW_ST_HOLD |-> st_reg.rst_cnt == 32'h00000000
    ) else $error("pulse count not held at zero in hold");

    chk_hold_exit: assert property ( // R02
        (st_reg.fsm == RSW_ST_HOLD && manual_reset_n) |=>
            st_reg.fsm == RSW_ST_PULSE &&
            st_reg.rst_cnt == 32'h00000000
    ) else $error("manual release did not start a full pulse");

    chk_pulse_step: assert property ( // R16
        (st_reg.fsm == RSW_ST_PULSE && manual_reset_n &&
         st_reg.rst_cnt < RST_LAST) |=>
            st_reg.fsm == RSW_ST_PULSE &&
            st_reg.rst_cnt == $past(st_reg.rst_cnt) + 32'h00000001
    ) else $error("pulse counter did not advance by one");

    chk_out_state: assert property ( // R02
        reset_out_n == (st_reg.fsm == RSW_ST_RUN)
    ) else $error("reset output disagrees with sequencer state");

    // Limit and enable selection checks
    chk_base_limit: assert property ( // R04
        (!IS_WINDOW && !wdog_range_sel) |-> wd_lim == BASE_LIM
    ) else $error("basic period not selected");

    chk_ext_limit: assert property ( // R06
        (!IS_WINDOW && wdog_range_sel) |-> wd_lim == EXT_LIM
    ) else $error("extended period not selected");

    chk_pin_ground: assert property ( // R05
        !IS_WINDOW |-> wd_en == !PIN_GND
    ) else $error("grounded timing pin not honoured");

    chk_strap_off: assert property ( // R10 R11
        (IS_WINDOW && window_strap0 && !window_strap1) |-> !wd_en
    ) else $error("strap disable combination left watchdog on");

    chk_slow_limit: assert property ( // R08
        IS_WINDOW |-> wd_lim == SLOW_LIM
    ) else $error("windowed limit not the slow limit");

    chk_ratio_set: assert property ( // R15
        (IS_WINDOW && wd_en) |->
            ratio_shift inside {3'h3, 3'h4, 3'h6}
    ) else $error("window ratio outside the allowed set");

    // Timer checks
    chk_kick_clear: assert property ( // R14
        (st_reg.fsm == RSW_ST_RUN && kick_ok) |=>
            st_reg.wd_cnt == 32'h00000000
    ) else $error("valid kick did not clear timer");

    chk_timer_counts: assert property ( // R14
        (st_reg.fsm == RSW_ST_RUN && manual_reset_n && wd_en &&
         !kick_fall && !range_chg && !late) |=>
            st_reg.wd_cnt == $past(st_reg.wd_cnt) + 32'h00000001
    ) else $error("watchdog timer did not advance");

endmodule
`default_nettype wire
